/* shared/scc_params.svh */
// timing counts, field encodings and reset values of the sequencer control
`ifndef SCC_PARAMS_SVH
`define SCC_PARAMS_SVH

`define SCC_CLK_HZ 25000000
`define SCC_STEP_US 250
`define SCC_STEP_CYCLES ((`SCC_CLK_HZ / 1000000) * `SCC_STEP_US)
`define SCC_STEPS_PER_MS 2'd3
`define SCC_MS_PER_LP 7'd99
`define SCC_LONG_STEP_MULT 7'd4
`define SCC_SHORT_STEP_MULT 7'd1
`define SCC_DEB_BASE_MS 7'd5
`define SCC_FORCE_DELAY_MS 16'd100
`define SCC_OFF_PIN_CTL 2'h0
`define SCC_OFF_RST 2'h0
`define SCC_EN_RST 12'h000
`define SCC_OE_N_RST 12'hfff
`define SCC_LAST_SLOT 2'h3
`define SCC_AF_LSB 8

`endif

/* shared/scc_pkg.sv */
// types shared by the sequencer control modules
`default_nettype none
package scc_pkg;
   typedef enum logic [1:0] {
      SCC_SEQ_RISE,
      SCC_SEQ_FALL,
      SCC_SEQ_DOZE_ENTER,
      SCC_SEQ_DOZE_LEAVE
   } scc_seq_t;
   typedef enum logic {
      SCC_ST_IDLE,
      SCC_ST_RUN
   } scc_state_t;
   typedef logic [11:0] scc_chan_t;
   typedef logic [3:0][11:0] scc_map_t;
endpackage
`default_nettype wire

/* shared/scc_deb_if.sv */
// link between the control core and one input debounce filter
`timescale 1ns/1ps
`default_nettype none
interface scc_deb_if;
   logic raw;
   logic on;
   logic tick;
   logic [3:0] interval;
   logic filt;
   modport core (output raw, output on, output tick, output interval,
                 input filt);
   modport filter (input raw, input on, input tick, input interval,
                   output filt);
endinterface
`default_nettype wire

/* core/scc_debounce.sv */
// debounce filter for one alternate-function input
`timescale 1ns/1ps
`default_nettype none
`include "scc_params.svh"
module scc_debounce
   import scc_pkg::*;
(
   input wire logic clk_i,
   input wire logic arst_n_i,
   scc_deb_if.filter dif
);
   logic filt_q, filt_d;
   logic [6:0] cnt_q, cnt_d;
   logic [6:0] limit;

   // interval code n selects 5 ms * (n + 1)
   assign limit = 7'(({3'h0, dif.interval} + 7'h1) * `SCC_DEB_BASE_MS);

   always_comb begin
      filt_d = filt_q;
      cnt_d = cnt_q;
      if (!dif.on) begin
         filt_d = dif.raw;
         cnt_d = 7'h00;
      end else if (dif.raw == filt_q) begin
         cnt_d = 7'h00;
      end else if (dif.tick) begin
         // accept the new level only after it held a whole interval
         if (cnt_q + 7'h1 >= limit) begin
            filt_d = dif.raw;
            cnt_d = 7'h00;
         end else begin
            cnt_d = cnt_q + 7'h1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         filt_q <= 1'b1;
         cnt_q <= 7'h00;
      end else begin
         filt_q <= filt_d;
         cnt_q <= cnt_d;
      end
   end

   assign dif.filt = filt_q;
endmodule
`default_nettype wire

/* core/scc_control.sv */
// control and configuration core of a twelve-channel rail sequencer
// Function
// - upper four enable pins select open-drain or push-pull drive each.
// - per-pin debounce enable; shared interval of 5 to 80 ms.
// - button press is long once it exceeds the programmed 100 ms steps.
// - reload one-time settings after shutdown completes, only if enabled.
// - force bit drives interrupt low; otherwise interrupt follows faults.
// - hold bit set by sequencer, cleared by host; freezes sleep pin.
// - forced-off field: pin control, or force off then resume later.
// - alarm match wakes the system only when enabled.
// - with checking on, missing check byte is good unless required.
// - host bit turns packet error checking on or off.
// - run self test after power-on reset when enabled.
// - run self test on leaving deep shutdown only when enabled.
// - four slot maps of twelve outputs for each of four sequences.
`timescale 1ns/1ps
`default_nettype none
`include "scc_params.svh"
module scc_control
   import scc_pkg::*;
#(
   parameter logic [12:0] STEP_CYCLES = 13'(`SCC_STEP_CYCLES)
)(
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [3:0] af_pin_i,
   input wire logic [3:0] debounce_on_i,
   input wire logic [3:0] debounce_sel_i,
   output logic [3:0] af_filt_o,
   input wire logic [3:0] gpo_push_pull_i,
   output logic [11:0] en_o,
   output logic [11:0] en_oe_n_o,
   input wire logic power_button_n_i,
   input wire logic [7:0] long_press_limit_i,
   output logic long_press_o,
   input wire logic reload_on_i,
   input wire logic shutdown_done_i,
   output logic otp_reload_o,
   input wire logic force_irq_i,
   input wire logic fault_i,
   output logic irq_out_n_o,
   input wire logic hold_set_i,
   input wire logic hold_clear_i,
   input wire logic sleep_pin_i,
   output logic hold_active_o,
   output logic sleep_req_o,
   input wire logic host_off_we_i,
   input wire logic [1:0] host_off_i,
   input wire logic wdt_off_we_i,
   input wire logic [1:0] wdt_off_i,
   input wire logic wake_pin_i,
   output logic [1:0] forced_off_ctl_o,
   output logic shutdown_req_o,
   input wire logic alarm_power_up_on_i,
   input wire logic alarm_match_i,
   output logic alarm_wake_o,
   input wire logic check_byte_on_i,
   input wire logic check_byte_required_i,
   input wire logic txn_done_i,
   input wire logic txn_has_pec_i,
   input wire logic txn_pec_ok_i,
   output logic txn_good_o,
   output logic txn_bad_o,
   input wire logic selftest_on_boot_i,
   input wire logic selftest_on_wake_i,
   input wire logic deep_exit_i,
   output logic selftest_start_o,
   input wire logic seq_start_i,
   input wire scc_seq_t seq_kind_i,
   input wire scc_map_t rise_map_i,
   input wire scc_map_t fall_map_i,
   input wire scc_map_t doze_enter_map_i,
   input wire scc_map_t doze_leave_map_i,
   input wire logic [3:0] rise_slot_len_i,
   input wire logic [3:0] fall_slot_len_i,
   input wire logic slot_multiplier_i,
   output logic seq_busy_o,
   output logic seq_done_o
);
   // pin synchronisers: first stage is read only by the second
   logic [6:0] sy1_q, sy1_d, sy2_q, sy2_d;
   always_comb begin
      sy1_d = {wake_pin_i, sleep_pin_i, power_button_n_i, af_pin_i};
      sy2_d = sy1_q;
   end
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sy1_q <= 7'h7f;
         sy2_q <= 7'h7f;
      end else begin
         sy1_q <= sy1_d;
         sy2_q <= sy2_d;
      end
   end

   // time base: 250 us step, 1 ms and 100 ms ticks
   logic [12:0] step_cnt_q, step_cnt_d;
   logic [1:0] ms_cnt_q, ms_cnt_d;
   logic [6:0] lp_cnt_q, lp_cnt_d;
   logic step_tick_q, step_tick_d, ms_tick_q, ms_tick_d, lp_tick_q, lp_tick_d;
   always_comb begin
      step_tick_d = (step_cnt_q == STEP_CYCLES - 13'h1);
      step_cnt_d = step_tick_d ? 13'h0000 : step_cnt_q + 13'h1;
      ms_cnt_d = ms_cnt_q;
      ms_tick_d = 1'b0;
      lp_cnt_d = lp_cnt_q;
      lp_tick_d = 1'b0;
      if (step_tick_q) begin
         ms_tick_d = (ms_cnt_q == `SCC_STEPS_PER_MS);
         ms_cnt_d = ms_tick_d ? 2'h0 : ms_cnt_q + 2'h1;
      end
      if (ms_tick_q) begin
         lp_tick_d = (lp_cnt_q == `SCC_MS_PER_LP);
         lp_cnt_d = lp_tick_d ? 7'h00 : lp_cnt_q + 7'h1;
      end
   end
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         step_cnt_q <= 13'h0000;
         ms_cnt_q <= 2'h0;
         lp_cnt_q <= 7'h00;
         step_tick_q <= 1'b0;
         ms_tick_q <= 1'b0;
         lp_tick_q <= 1'b0;
      end else begin
         step_cnt_q <= step_cnt_d;
         ms_cnt_q <= ms_cnt_d;
         lp_cnt_q <= lp_cnt_d;
         step_tick_q <= step_tick_d;
         ms_tick_q <= ms_tick_d;
         lp_tick_q <= lp_tick_d;
      end
   end

   // debounce filters on the alternate-function inputs
   logic [3:0] filt;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_deb
         scc_deb_if dif ();
         assign dif.raw = sy2_q[gi];
         assign dif.on = debounce_on_i[gi];
         assign dif.tick = ms_tick_q;
         assign dif.interval = debounce_sel_i;
         assign filt[gi] = dif.filt;
         scc_debounce u_deb (
            .clk_i(clk_i),
            .arst_n_i(arst_n_i),
            .dif(dif)
         );
      end
   endgenerate

   // misc control state
   logic [8:0] press_q, press_d;
   logic long_q, long_d, hold_q, hold_d, sleep_q, sleep_d;
   logic irq_n_q, irq_n_d, reload_q, reload_d, wake_q, wake_d;
   logic good_q, good_d, bad_q, bad_d, boot_q, boot_d, st_q, st_d;
   logic [1:0] off_q, off_d;
   logic [15:0] off_cnt_q, off_cnt_d;
   logic shut_q, shut_d;
   logic [3:0] filt_q;
   always_comb begin
      press_d = press_q;
      if (sy2_q[4]) begin
         press_d = 9'h000;
      end else if (lp_tick_q && press_q <= {1'b0, long_press_limit_i}) begin
         press_d = press_q + 9'h001;
      end
      // held longer than limit * 100 ms (limit + 1 ticks of the free-running 100 ms base)
      long_d = press_d > {1'b0, long_press_limit_i};
      reload_d = shutdown_done_i & reload_on_i;
      irq_n_d = force_irq_i ? 1'b0 : ~fault_i;
      // a set arriving with the host clear still wins
      hold_d = hold_set_i | (hold_q & ~hold_clear_i);
      sleep_d = hold_q ? sleep_q : sy2_q[5];
      off_d = off_q;
      off_cnt_d = off_cnt_q;
      if (wdt_off_we_i) begin
         off_d = wdt_off_i;
         off_cnt_d = 16'h0000;
      end else if (host_off_we_i) begin
         off_d = host_off_i;
         off_cnt_d = 16'h0000;
      end else if (off_q != `SCC_OFF_PIN_CTL && ms_tick_q) begin
         if (off_cnt_q + 16'h0001 >= `SCC_FORCE_DELAY_MS) begin
            off_d = `SCC_OFF_PIN_CTL;
            off_cnt_d = 16'h0000;
         end else begin
            off_cnt_d = off_cnt_q + 16'h0001;
         end
      end
      shut_d = (off_q != `SCC_OFF_PIN_CTL) | ~sy2_q[6];
      wake_d = alarm_match_i & alarm_power_up_on_i;
      good_d = 1'b0;
      bad_d = 1'b0;
      if (txn_done_i) begin
         if (!check_byte_on_i) begin
            good_d = 1'b1;
         end else if (txn_has_pec_i) begin
            good_d = txn_pec_ok_i;
            bad_d = ~txn_pec_ok_i;
         end else begin
            good_d = ~check_byte_required_i;
            bad_d = check_byte_required_i;
         end
      end
      // the boot request is sampled in the first cycle after release
      boot_d = 1'b1;
      st_d = (~boot_q & selftest_on_boot_i)
           | (deep_exit_i & selftest_on_wake_i);
   end
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         press_q <= 9'h000;
         long_q <= 1'b0;
         reload_q <= 1'b0;
         irq_n_q <= 1'b1;
         hold_q <= 1'b0;
         sleep_q <= 1'b1;
         off_q <= `SCC_OFF_RST;
         off_cnt_q <= 16'h0000;
         shut_q <= 1'b1;
         wake_q <= 1'b0;
         good_q <= 1'b0;
         bad_q <= 1'b0;
         boot_q <= 1'b0;
         st_q <= 1'b0;
         filt_q <= 4'hf;
      end else begin
         press_q <= press_d;
         long_q <= long_d;
         reload_q <= reload_d;
         irq_n_q <= irq_n_d;
         hold_q <= hold_d;
         sleep_q <= sleep_d;
         off_q <= off_d;
         off_cnt_q <= off_cnt_d;
         shut_q <= shut_d;
         wake_q <= wake_d;
         good_q <= good_d;
         bad_q <= bad_d;
         boot_q <= boot_d;
         st_q <= st_d;
         filt_q <= filt;
      end
   end

   // slot stepper
   scc_state_t state_q, state_d;
   scc_seq_t kind_q, kind_d;
   logic [1:0] slot_q, slot_d;
   logic [6:0] dur_q, dur_d;
   logic [11:0] en_q, en_d, oe_n_q, oe_n_d;
   logic done_q, done_d, busy_q, busy_d;
   scc_map_t map_sel;
   logic [3:0] len_sel;
   logic [6:0] slot_steps;
   logic up;
   always_comb begin
      kind_d = kind_q;
      if (state_q == SCC_ST_IDLE && seq_start_i) begin
         kind_d = seq_kind_i;
      end
      unique case (kind_d)
         SCC_SEQ_RISE: map_sel = rise_map_i;
         SCC_SEQ_FALL: map_sel = fall_map_i;
         SCC_SEQ_DOZE_ENTER: map_sel = doze_enter_map_i;
         SCC_SEQ_DOZE_LEAVE: map_sel = doze_leave_map_i;
      endcase
      up = (kind_d == SCC_SEQ_RISE) || (kind_d == SCC_SEQ_DOZE_LEAVE);
      len_sel = up ? rise_slot_len_i : fall_slot_len_i;
      slot_steps = 7'(({3'h0, len_sel} + 7'h1) * (slot_multiplier_i ?
                   `SCC_LONG_STEP_MULT : `SCC_SHORT_STEP_MULT));
      state_d = state_q;
      slot_d = slot_q;
      dur_d = dur_q;
      en_d = en_q;
      done_d = 1'b0;
      unique case (state_q)
         SCC_ST_IDLE: begin
            if (seq_start_i) begin
               state_d = SCC_ST_RUN;
               slot_d = 2'h0;
               dur_d = 7'h00;
               en_d = up ? (en_q | map_sel[0]) : (en_q & ~map_sel[0]);
            end
         end
         SCC_ST_RUN: begin
            if (step_tick_q) begin
               if (dur_q + 7'h1 >= slot_steps) begin
                  dur_d = 7'h00;
                  if (slot_q == `SCC_LAST_SLOT) begin
                     state_d = SCC_ST_IDLE;
                     done_d = 1'b1;
                  end else begin
                     slot_d = slot_q + 2'h1;
                     en_d = up ? (en_q | map_sel[slot_d])
                               : (en_q & ~map_sel[slot_d]);
                  end
               end else begin
                  dur_d = dur_q + 7'h1;
               end
            end
         end
      endcase
      busy_d = (state_d == SCC_ST_RUN);
      // open drain drives only the low level; lower pins are push-pull
      oe_n_d = 12'h000;
      for (int k = 0; k < 4; k++) begin
         if (!gpo_push_pull_i[k]) begin
            oe_n_d[`SCC_AF_LSB + k] = en_d[`SCC_AF_LSB + k];
         end
      end
   end
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_q <= SCC_ST_IDLE;
         kind_q <= SCC_SEQ_RISE;
         slot_q <= 2'h0;
         dur_q <= 7'h00;
         en_q <= `SCC_EN_RST;
         oe_n_q <= `SCC_OE_N_RST;
         done_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         state_q <= state_d;
         kind_q <= kind_d;
         slot_q <= slot_d;
         dur_q <= dur_d;
         en_q <= en_d;
         oe_n_q <= oe_n_d;
         done_q <= done_d;
         busy_q <= busy_d;
      end
   end

   assign af_filt_o = filt_q;
   assign en_o = en_q;
   assign en_oe_n_o = oe_n_q;
   assign long_press_o = long_q;
   assign otp_reload_o = reload_q;
   assign irq_out_n_o = irq_n_q;
   assign hold_active_o = hold_q;
   assign sleep_req_o = sleep_q;
   assign forced_off_ctl_o = off_q;
   assign shutdown_req_o = shut_q;
   assign alarm_wake_o = wake_q;
   assign txn_good_o = good_q;
   assign txn_bad_o = bad_q;
   assign selftest_start_o = st_q;
   assign seq_busy_o = busy_q;
   assign seq_done_o = done_q;
endmodule
`default_nettype wire

/* verification/scc_control_monitor.sv */
// port-level assertions for the sequencer control core
`timescale 1ns/1ps
`default_nettype none
module scc_control_monitor
   import scc_pkg::*;
#(
   parameter logic [12:0] STEP_CYCLES = 13'h0004
)(
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic force_irq_i,
   input wire logic fault_i,
   input wire logic irq_out_n_o,
   input wire logic shutdown_done_i,
   input wire logic reload_on_i,
   input wire logic otp_reload_o,
   input wire logic txn_done_i,
   input wire logic txn_has_pec_i,
   input wire logic check_byte_on_i,
   input wire logic check_byte_required_i,
   input wire logic txn_good_o,
   input wire logic txn_bad_o,
   input wire logic hold_set_i,
   input wire logic hold_active_o,
   input wire logic sleep_req_o,
   input wire logic wdt_off_we_i,
   input wire logic [1:0] wdt_off_i,
   input wire logic [1:0] forced_off_ctl_o,
   input wire logic [3:0] gpo_push_pull_i,
   input wire logic [11:0] en_o,
   input wire logic [11:0] en_oe_n_o,
   input wire logic seq_start_i,
   input wire logic seq_busy_o,
   input wire scc_seq_t seq_kind_i,
   input wire scc_map_t rise_map_i
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   sequence s_rise_go;
      seq_start_i && !seq_busy_o && seq_kind_i == SCC_SEQ_RISE;
   endsequence
   sequence s_missing_pec;
      txn_done_i && !txn_has_pec_i;
   endsequence
   a_irq_follow: assert property (1'b1 |=>
      irq_out_n_o == !($past(force_irq_i) || $past(fault_i)))
      else $error("irq output does not follow force and fault");
   a_reload_gate: assert property (shutdown_done_i |=>
      otp_reload_o == $past(reload_on_i))
      else $error("reload pulse does not match its enable");
   a_pec_missing: assert property (s_missing_pec |=> txn_good_o !=
      txn_bad_o && txn_bad_o == ($past(check_byte_on_i) &&
      $past(check_byte_required_i)))
      else $error("missing check byte judged wrongly");
   a_hold_set: assert property (hold_set_i |=> hold_active_o)
      else $error("hold bit not set");
   a_hold_freeze: assert property (hold_active_o |=> $stable(sleep_req_o))
      else $error("sleep request moved while held");
   a_wdt_wins: assert property (wdt_off_we_i |=>
      forced_off_ctl_o == $past(wdt_off_i))
      else $error("watchdog write not taken");
   a_oe_drive: assert property (1'b1 |=> en_oe_n_o ==
      {en_o[11:8] & ~$past(gpo_push_pull_i), 8'h00})
      else $error("enable drive mode wrong");
   a_rise_slot0: assert property (s_rise_go |=> seq_busy_o &&
      (en_o & $past(rise_map_i[0])) == $past(rise_map_i[0]))
      else $error("first slot not applied");
endmodule
bind scc_control scc_control_monitor #(.STEP_CYCLES(STEP_CYCLES)) u_mon (.*);
`default_nettype wire

/* verification/scc_host_model.sv */
// host side model: bus transaction results and alarm events
`timescale 1ns/1ps
`default_nettype none
module scc_host_model (
   input wire logic clk_i,
   output logic txn_done_o,
   output logic txn_has_pec_o,
   output logic txn_pec_ok_o,
   output logic alarm_match_o
);
   logic time_set = 1'b0;
   initial {txn_done_o, txn_has_pec_o, txn_pec_ok_o, alarm_match_o} = '0;
   // qualifiers flip after the transfer so stale values never pass
   task automatic send_txn(input logic has, input logic ok);
      txn_done_o = 1'b1;
      txn_has_pec_o = has;
      txn_pec_ok_o = ok;
      @(posedge clk_i);
      #1;
      txn_done_o = 1'b0;
      txn_has_pec_o = ~has;
      txn_pec_ok_o = ~ok;
   endtask
   task automatic set_time();
      time_set = 1'b1;
   endtask
   task automatic fire_alarm();
      if (time_set) begin
         alarm_match_o = 1'b1;
         @(posedge clk_i);
         #1;
         alarm_match_o = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

/* verification/testbench.sv */
// self-checking testbench for the sequencer control core
`timescale 1ns/1ps
`default_nettype none
module testbench
   import scc_pkg::*;
;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [3:0] af_pin_i, debounce_on_i, debounce_sel_i, af_filt_o;
   logic [3:0] gpo_push_pull_i, rise_slot_len_i, fall_slot_len_i;
   logic [11:0] en_o, en_oe_n_o;
   logic [7:0] long_press_limit_i;
   logic [1:0] host_off_i, wdt_off_i, forced_off_ctl_o;
   logic power_button_n_i, long_press_o, reload_on_i, shutdown_done_i;
   logic otp_reload_o, force_irq_i, fault_i, irq_out_n_o, hold_set_i;
   logic hold_clear_i, sleep_pin_i, hold_active_o, sleep_req_o;
   logic host_off_we_i, wdt_off_we_i, wake_pin_i, shutdown_req_o;
   logic alarm_power_up_on_i, alarm_match_i, alarm_wake_o, txn_done_i;
   logic check_byte_on_i, check_byte_required_i, txn_has_pec_i;
   logic txn_pec_ok_i, txn_good_o, txn_bad_o, selftest_on_boot_i;
   logic selftest_on_wake_i, deep_exit_i, selftest_start_o, seq_start_i;
   logic slot_multiplier_i, seq_busy_o, seq_done_o;
   scc_seq_t seq_kind_i;
   scc_map_t rise_map_i, fall_map_i, doze_enter_map_i, doze_leave_map_i;
   int err_total = 0;
   int checked = 0;
   // short step keeps the millisecond timers within a brief run
   scc_control #(.STEP_CYCLES(13'h0004)) dut (.*);
   scc_host_model hm (.clk_i(clk_i), .txn_done_o(txn_done_i),
      .txn_has_pec_o(txn_has_pec_i), .txn_pec_ok_o(txn_pec_ok_i),
      .alarm_match_o(alarm_match_i));
   always #20 clk_i = ~clk_i;
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic chk_bit(input string n, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("FAIL %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic chk_vec(input string n, input logic [11:0] e,
         input logic [11:0] g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic t_boot(input logic b);
      arst_n_i = 1'b0;
      selftest_on_boot_i = b;
      cyc(10);
      chk_vec("rst en", 12'h000, en_o);
      chk_vec("rst oe", 12'hfff, en_oe_n_o);
      chk_bit("rst irq", 1'b1, irq_out_n_o);
      arst_n_i = 1'b1;
      cyc(1);
      chk_bit("boot test", b, selftest_start_o);
      selftest_on_boot_i = 1'b0;
      cyc(1);
      chk_bit("boot test end", 1'b0, selftest_start_o);
   endtask
   task automatic t_irq();
      for (int i = 0; i < 4; i++) begin
         {force_irq_i, fault_i} = i[1:0];
         cyc(1);
         chk_bit("irq", !(i[1] || i[0]), irq_out_n_o);
      end
      {force_irq_i, fault_i} = 2'h0;
   endtask
   task automatic t_pulses();
      hm.set_time();
      for (int e = 0; e < 2; e++) begin
         {reload_on_i, alarm_power_up_on_i, selftest_on_wake_i} = {3{e[0]}};
         {shutdown_done_i, deep_exit_i} = 2'h3;
         hm.fire_alarm();
         {shutdown_done_i, deep_exit_i} = 2'h0;
         chk_bit("reload", e[0], otp_reload_o);
         chk_bit("alarm wake", e[0], alarm_wake_o);
         chk_bit("wake test", e[0], selftest_start_o);
         cyc(1);
      end
   endtask
   task automatic t_hold();
      {hold_set_i, hold_clear_i} = 2'h3;
      cyc(1);
      {hold_set_i, hold_clear_i} = 2'h0;
      chk_bit("hold set", 1'b1, hold_active_o);
      sleep_pin_i = 1'b0;
      cyc(5);
      chk_bit("sleep frozen", 1'b1, sleep_req_o);
      hold_clear_i = 1'b1;
      cyc(1);
      hold_clear_i = 1'b0;
      chk_bit("hold clear", 1'b0, hold_active_o);
      cyc(4);
      chk_bit("sleep follows", 1'b0, sleep_req_o);
      sleep_pin_i = 1'b1;
   endtask
   task automatic t_pec();
      logic g;
      for (int i = 0; i < 16; i++) begin
         {check_byte_on_i, check_byte_required_i} = i[3:2];
         hm.send_txn(i[1], i[0]);
         g = !i[3] || (i[1] ? i[0] : !i[2]);
         chk_bit("txn good", g, txn_good_o);
         chk_bit("txn bad", !g, txn_bad_o);
         cyc(1);
      end
   endtask
   task automatic t_off();
      int n;
      n = 0;
      {host_off_we_i, host_off_i} = 3'h7;
      cyc(1);
      chk_vec("host off", 12'h003, {10'h000, forced_off_ctl_o});
      {host_off_i, wdt_off_we_i, wdt_off_i} = 5'h0e;
      cyc(1);
      {host_off_we_i, wdt_off_we_i} = 2'h0;
      chk_vec("wdt off", 12'h002, {10'h000, forced_off_ctl_o});
      cyc(1);
      chk_bit("forced down", 1'b1, shutdown_req_o);
      while (forced_off_ctl_o !== 2'h0 && n < 2000) begin
         cyc(1);
         n++;
      end
      chk_bit("off resume", 1'b1, n >= 1570 && n <= 1630);
      cyc(2);
      chk_bit("pin control", 1'b0, shutdown_req_o);
      wake_pin_i = 1'b0;
      cyc(4);
      chk_bit("pin down", 1'b1, shutdown_req_o);
      wake_pin_i = 1'b1;
   endtask
   task automatic t_deb();
      af_pin_i = 4'h0;
      cyc(4);
      chk_vec("raw af", 12'h000, {8'h00, af_filt_o});
      {debounce_on_i, debounce_sel_i, af_pin_i} = 12'hf1f;
      cyc(100);
      chk_vec("af held", 12'h000, {8'h00, af_filt_o});
      cyc(120);
      chk_vec("af passed", 12'h00f, {8'h00, af_filt_o});
   endtask
   task automatic t_long();
      long_press_limit_i = 8'h01;
      power_button_n_i = 1'b0;
      cyc(1500);
      chk_bit("short press", 1'b0, long_press_o);
      cyc(1900);
      chk_bit("long press", 1'b1, long_press_o);
      power_button_n_i = 1'b1;
      cyc(4);
      chk_bit("released", 1'b0, long_press_o);
   endtask
   task automatic t_seq(input scc_seq_t k, input logic [11:0] e0,
         input logic [11:0] e, input int lo, input int hi);
      int n;
      n = 0;
      seq_kind_i = k;
      seq_start_i = 1'b1;
      cyc(1);
      seq_start_i = 1'b0;
      chk_vec("slot0 en", e0, en_o);
      while (seq_busy_o === 1'b1 && n < 400) begin
         cyc(1);
         n++;
      end
      chk_bit("seq span", 1'b1, n >= lo && n <= hi);
      chk_bit("seq done", 1'b1, seq_done_o);
      chk_vec("seq end", e, en_o);
      chk_vec("drive", {e[11:8] & ~gpo_push_pull_i, 8'h00}, en_oe_n_o);
      cyc(2);
   endtask
   initial begin
      {debounce_on_i, debounce_sel_i, gpo_push_pull_i, reload_on_i} = '0;
      {shutdown_done_i, force_irq_i, fault_i, hold_set_i, hold_clear_i} = '0;
      {host_off_we_i, wdt_off_we_i, host_off_i, wdt_off_i} = '0;
      {alarm_power_up_on_i, check_byte_on_i, check_byte_required_i} = '0;
      {selftest_on_wake_i, deep_exit_i, seq_start_i, long_press_limit_i} = '0;
      {rise_slot_len_i, fall_slot_len_i, slot_multiplier_i} = '0;
      {rise_map_i, fall_map_i, doze_enter_map_i, doze_leave_map_i} = '0;
      seq_kind_i = SCC_SEQ_RISE;
      {af_pin_i, power_button_n_i, wake_pin_i, sleep_pin_i} = '1;
      t_boot(1'b1);
      t_boot(1'b0);
      t_irq();
      t_pulses();
      t_hold();
      t_pec();
      t_off();
      t_deb();
      t_long();
      rise_map_i[0] = 12'h00f;
      rise_map_i[1] = 12'h0f0;
      rise_map_i[2] = 12'hf00;
      fall_map_i[1] = 12'hf0f;
      doze_enter_map_i[0] = 12'h0f0;
      doze_leave_map_i[3] = 12'h00f;
      {gpo_push_pull_i, rise_slot_len_i, slot_multiplier_i} = 9'h0a3;
      t_seq(SCC_SEQ_RISE, 12'h00f, 12'hfff, 96, 140);
      t_seq(SCC_SEQ_FALL, 12'hfff, 12'h0f0, 48, 76);
      t_seq(SCC_SEQ_DOZE_ENTER, 12'h000, 12'h000, 48, 76);
      t_seq(SCC_SEQ_DOZE_LEAVE, 12'h000, 12'h00f, 96, 140);
      slot_multiplier_i = 1'b0;
      t_seq(SCC_SEQ_FALL, 12'h00f, 12'h000, 12, 17);
      final_report();
   end
   // whole run is near six thousand cycles; this limit is far beyond it
   initial begin
      #2000000;
      err_total++;
      final_report();
   end
endmodule
`default_nettype wire
